// ### hnp_defs.svh
// Constants for the host negotiation block
`ifndef HNP_DEFS_SVH
`define HNP_DEFS_SVH

// ==========================================================
// Timing
`define CLK_HZ            40000000
`define IDLE_SUSPEND_MS   3
`define IDLE_SUSPEND_CYC  ((`CLK_HZ / 1000) * `IDLE_SUSPEND_MS)
`define SUSP_DELAY_CYC    16'h0010
`define RESET_MS          10
`define RESET_CYC         ((`CLK_HZ / 1000) * `RESET_MS)

// ==========================================================
// Register offsets (byte addresses)
`define REG_CTRL   4'h0
`define REG_STAT   4'h4
`define REG_IRQ    4'h8
`define REG_MASK   4'hC

// ==========================================================
// Control bit positions
`define C_HOST_HNP_EN  0
`define C_PORT_SUSP    1
`define C_DEV_HNP_EN   2
`define C_HNP_REQ      3
`define C_PORT_PWR     4
`define C_PORT_RST     5
`define CTRL_W         6

// Status bit positions
`define S_ROLE_HOST    0
`define S_ID_B         1
`define S_NEG_OK       2
`define S_PORT_EN      3
`define S_CONNECTED    4
`define STAT_W         5

// Interrupt bit positions
`define I_NEG_DET      0
`define I_EARLY_SUSP   1
`define I_BUS_SUSP     2
`define I_ID_CHANGE    3
`define I_NEG_OK       4
`define I_PORT_CONN    5
`define I_PORT_ENCHG   6
`define IRQ_W          7

`endif

// ### hnp_pkg.sv
// Types for the host negotiation block
package hnp_pkg;
    typedef enum logic [2:0] {
        A_HOST,
        A_PERIPH,
        B_PERIPH,
        B_WAIT_CONN,
        B_HOST
    } role_state_t;
endpackage

// ### idle_timer.sv
// Bus idle timer: early suspend and full suspend pulses
`timescale 1ns/100ps
`default_nettype none
`include "hnp_defs.svh"

module idle_timer #(
    parameter int unsigned IDLE_CYC = `IDLE_SUSPEND_CYC
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Bus state
    input  wire logic idle_i,
    // Events
    output logic      early_o,
    output logic      suspend_o
);
    localparam int unsigned SUSP_CYC = IDLE_CYC + `SUSP_DELAY_CYC;

    logic [17:0] count_reg;
    logic        at_early;
    logic        at_susp;

    assign at_early  = (count_reg == 18'(IDLE_CYC - 1));
    assign at_susp   = (count_reg == 18'(SUSP_CYC - 1));
    assign early_o   = idle_i && at_early;
    assign suspend_o = idle_i && at_susp;

    always_ff @(posedge clock_i) begin
        if (rst_i || !idle_i) begin
            count_reg <= 18'h00000;
        end else if (count_reg != 18'(SUSP_CYC)) begin
            count_reg <= count_reg + 18'h00001;
        end
    end
endmodule
`default_nettype wire

// ### otg_host_negotiation.sv
// Host negotiation role-swap logic with Wishbone register access
//
// What this block does
// - B disconnect in suspend flags negotiation detected
// - Device role clears both pull-down enables
// - Early suspend after 3 ms idle, then suspend
// - A negotiated: peer suspend returns host, pull-downs
// - A negotiation end raises connector ID change
// - B with request disconnects after suspend flagged
// - B taking host asserts both pull-downs
// - B success raises status-change and success bit
// - Attach raises port connect interrupt
// - Port reset bit issues USB reset
// - Port enable change raised after reset
// - B reclaimed by A returns to device
`timescale 1ns/100ps
`default_nettype none
`include "hnp_defs.svh"

module otg_host_negotiation
    import hnp_pkg::*;
#(
    parameter int unsigned RESET_CYC = `RESET_CYC,
    parameter int unsigned IDLE_CYC  = `IDLE_SUSPEND_CYC
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Transceiver pins
    input  wire logic        id_pin_i,
    input  wire logic        se0_i,
    input  wire logic        dp_high_i,
    output logic             dp_pulldown_o,
    output logic             dm_pulldown_o,
    output logic             dp_pullup_o,
    output logic             drive_vbus_o,
    output logic             bus_reset_o,
    // Interrupt
    output logic             irq_o
);
    // ==========================================================
    // Pin synchronisers
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic       id_b;
    logic       se0;
    logic       dp_high;

    always_ff @(posedge clock_i) begin
        pin_meta_reg <= {id_pin_i, se0_i, dp_high_i};
        pin_sync_reg <= pin_meta_reg;
    end

    assign id_b    = pin_sync_reg[2];
    assign se0     = pin_sync_reg[1];
    assign dp_high = pin_sync_reg[0];

    // ==========================================================
    // Registers
    role_state_t             state_reg;
    role_state_t             state_next;
    logic [`CTRL_W-1:0]      ctrl_reg;
    logic [`IRQ_W-1:0]       irq_reg;
    logic [`IRQ_W-1:0]       mask_reg;
    logic [`IRQ_W-1:0]       event_set;
    logic                    neg_ok_reg;
    logic                    port_en_reg;
    logic                    connected_reg;
    logic                    id_b_reg;
    logic                    ack_reg;
    logic [31:0]             dat_reg;
    logic [31:0]             reset_cnt_reg;
    logic                    resetting_reg;
    logic                    state_is_host;

    // ==========================================================
    // Bus decode
    wire bus_req   = cyc_i && stb_i && !ack_reg;
    wire wr_req    = bus_req && we_i && sel_i[0];
    wire hit_ctrl  = (adr_i == `REG_CTRL);
    wire hit_stat  = (adr_i == `REG_STAT);
    wire hit_irq   = (adr_i == `REG_IRQ);
    wire hit_mask  = (adr_i == `REG_MASK);
    wire wr_ctrl   = wr_req && hit_ctrl;
    wire wr_irq    = wr_req && hit_irq;
    wire wr_mask   = wr_req && hit_mask;

    wire [`STAT_W-1:0] stat_word = {
        connected_reg, port_en_reg, neg_ok_reg, id_b, state_is_host};

    wire [31:0] rd_mux =
        hit_ctrl ? {{(32-`CTRL_W){1'b0}}, ctrl_reg} :
        hit_stat ? {{(32-`STAT_W){1'b0}}, stat_word} :
        hit_irq  ? {{(32-`IRQ_W){1'b0}}, irq_reg} :
        hit_mask ? {{(32-`IRQ_W){1'b0}}, mask_reg} : 32'h00000000;

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign irq_o = |(irq_reg & mask_reg);

    // ==========================================================
    // Idle timer
    logic early_evt;
    logic susp_evt;

    // Bus idle is a steady SE0 seen through the synchroniser
    wire bus_idle = se0;

    idle_timer #(
        .IDLE_CYC  (IDLE_CYC)
    ) u_idle (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .idle_i    (bus_idle),
        .early_o   (early_evt),
        .suspend_o (susp_evt)
    );

    // ==========================================================
    // Role state and pin drive
    assign state_is_host = (state_reg == A_HOST) || (state_reg == B_HOST);
    wire host_hnp_en   = ctrl_reg[`C_HOST_HNP_EN];
    wire port_susp     = ctrl_reg[`C_PORT_SUSP];
    wire dev_hnp_en    = ctrl_reg[`C_DEV_HNP_EN];
    wire hnp_req       = ctrl_reg[`C_HNP_REQ];
    wire port_rst      = ctrl_reg[`C_PORT_RST];

    // Peer disconnect while we host a suspended bus
    wire peer_gone  = se0 && !dp_high;
    wire a_neg_det  = (state_reg == A_HOST) && !id_b && host_hnp_en
                      && port_susp && connected_reg && peer_gone;
    wire b_susp_ok  = (state_reg == B_PERIPH) && dev_hnp_en && hnp_req
                      && susp_evt;
    wire b_conn     = (state_reg == B_WAIT_CONN) && dp_high;
    wire attach     = state_is_host && !connected_reg && dp_high;
    wire detach     = state_is_host && connected_reg && peer_gone
                      && !resetting_reg && !a_neg_det;
    wire rst_done   = resetting_reg
                      && (reset_cnt_reg == 32'(RESET_CYC - 1));
    wire start_rst  = port_rst && !resetting_reg && connected_reg
                      && !port_en_reg;
    wire id_change  = (id_b != id_b_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            A_HOST: begin
                if (id_b) begin
                    state_next = B_PERIPH;
                end else if (a_neg_det) begin
                    state_next = A_PERIPH;
                end
            end
            A_PERIPH: begin
                if (susp_evt) begin
                    state_next = A_HOST;
                end
            end
            B_PERIPH: begin
                if (!id_b) begin
                    state_next = A_HOST;
                end else if (b_susp_ok) begin
                    state_next = B_WAIT_CONN;
                end
            end
            B_WAIT_CONN: begin
                if (b_conn) begin
                    state_next = B_HOST;
                end
            end
            B_HOST: begin
                if (port_susp && connected_reg && peer_gone) begin
                    state_next = B_PERIPH;
                end
            end
            default: begin
                state_next = A_HOST;
            end
        endcase
    end

    always_comb begin
        event_set = '0;
        event_set[`I_NEG_DET]    = a_neg_det;
        event_set[`I_EARLY_SUSP] = early_evt;
        event_set[`I_BUS_SUSP]   = susp_evt;
        event_set[`I_ID_CHANGE]  = id_change
            || (state_reg == A_PERIPH && susp_evt);
        event_set[`I_NEG_OK]     = b_conn;
        event_set[`I_PORT_CONN]  = attach || b_conn;
        event_set[`I_PORT_ENCHG] = rst_done || (detach && port_en_reg);
    end

    // Pull-downs follow the host role and B_WAIT_CONN
    assign dp_pulldown_o = state_is_host || state_reg == B_WAIT_CONN;
    assign dm_pulldown_o = dp_pulldown_o;
    // Pull-up only in the peripheral role while not disconnected
    assign dp_pullup_o   = (state_reg == A_PERIPH) || (state_reg == B_PERIPH);
    assign drive_vbus_o  = ctrl_reg[`C_PORT_PWR]
                           && state_is_host;
    assign bus_reset_o   = resetting_reg;

    // ==========================================================
    // Sequential logic
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_reg <= A_HOST;
            id_b_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            id_b_reg  <= id_b;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    // Read data stands until the next read
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dat_reg <= 32'h00000000;
        end else if (bus_req && !we_i) begin
            dat_reg <= rd_mux;
        end
    end

    // Port reset bit clears itself when the reset is done
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_reg <= '0;
        end else if (wr_ctrl) begin
            ctrl_reg <= dat_i[`CTRL_W-1:0];
        end else if (rst_done) begin
            ctrl_reg[`C_PORT_RST] <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            mask_reg <= '0;
        end else if (wr_mask) begin
            mask_reg <= dat_i[`IRQ_W-1:0];
        end
    end

    // Set wins over a write-one clear
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= (irq_reg & ~(wr_irq ? dat_i[`IRQ_W-1:0] : '0))
                       | event_set;
        end
    end

    // ==========================================================
    // Port status
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            neg_ok_reg <= 1'b0;
        end else if (b_conn) begin
            neg_ok_reg <= 1'b1;
        end else if (state_reg == B_PERIPH) begin
            neg_ok_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            connected_reg <= 1'b0;
        end else if (attach || b_conn) begin
            connected_reg <= 1'b1;
        end else if (detach || !state_is_host) begin
            connected_reg <= 1'b0;
        end
    end

    // Bus reset lasts RESET_CYC cycles
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            resetting_reg <= 1'b0;
            reset_cnt_reg <= 32'h00000000;
        end else if (start_rst) begin
            resetting_reg <= 1'b1;
            reset_cnt_reg <= 32'h00000000;
        end else if (rst_done) begin
            resetting_reg <= 1'b0;
        end else if (resetting_reg) begin
            reset_cnt_reg <= reset_cnt_reg + 32'h00000001;
        end
    end

    // Losing the peer or the host role disables the port
    always_ff @(posedge clock_i) begin
        if (rst_i || detach || !state_is_host) begin
            port_en_reg <= 1'b0;
        end else if (rst_done) begin
            port_en_reg <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### hnp_monitor.sv
// Port checker for the host negotiation block
`timescale 1ns/100ps
`default_nettype none

module hnp_monitor #(
    parameter int unsigned RESET_CYC = 20
) (
    // Clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // Transceiver and interrupt
    input wire logic        dp_pulldown_o,
    input wire logic        dm_pulldown_o,
    input wire logic        dp_pullup_o,
    input wire logic        drive_vbus_o,
    input wire logic        bus_reset_o,
    input wire logic        irq_o
);
    int unsigned rst_len_reg;

    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence
    sequence s_mask_off;
        ack_o && we_i && adr_i == 4'hC && sel_i[0] && dat_i[6:0] == 7'h00;
    endsequence

    // Length of the bus reset in cycles
    always_ff @(posedge clock_i) begin
        if (rst_i || !bus_reset_o) begin
            rst_len_reg <= 0;
        end else begin
            rst_len_reg <= rst_len_reg + 1;
        end
    end

    // ==========================================================
    // Assertions
    a_ack_one_shot: assert property (s_req |=> s_ack_pulse)
        else $error("ack is not one pulse after a request");
    a_pulldown_pair: assert property (
        dp_pulldown_o == dm_pulldown_o) else $error("pull-downs differ");
    a_pullup_flip: assert property (
        dp_pullup_o != dp_pulldown_o) else $error("pull-up clash");
    a_vbus_host_only: assert property (
        drive_vbus_o |-> dp_pulldown_o) else $error("vbus outside host");
    a_reset_length: assert property (
        $fell(bus_reset_o) |-> rst_len_reg == RESET_CYC)
        else $error("bus reset length wrong");
    a_reset_in_host: assert property (
        $rose(bus_reset_o) |-> dp_pulldown_o ##1 bus_reset_o)
        else $error("bus reset outside host role");
    a_mask_blocks_irq: assert property (s_mask_off |-> ##2 !irq_o)
        else $error("irq high with empty mask");
    a_reset_quiet: assert property (
        $fell(rst_i) |-> dp_pulldown_o && !ack_o && !irq_o && !drive_vbus_o)
        else $error("outputs wrong after reset");
endmodule

bind otg_host_negotiation hnp_monitor #(.RESET_CYC(RESET_CYC)) i_hnp_monitor (
    .clock_i(clock_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .ack_o(ack_o), .dp_pulldown_o(dp_pulldown_o),
    .dm_pulldown_o(dm_pulldown_o), .dp_pullup_o(dp_pullup_o),
    .drive_vbus_o(drive_vbus_o), .bus_reset_o(bus_reset_o), .irq_o(irq_o));

`default_nettype wire

// ### otg_peer_model.sv
// Peer controller model on the far side of the bus
`timescale 1ns/100ps
`default_nettype none

module otg_peer_model #(
    parameter int unsigned RESP_CYC = 8
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Commands from the bench
    input  wire logic attach_i,
    input  wire logic hnp_i,
    input  wire logic idle_i,
    // Line controls of the block
    input  wire logic dp_pullup_i,
    input  wire logic dp_pulldown_i,
    // Line state
    output logic      se0_o,
    output logic      dp_high_o
);
    logic       answer_reg;
    logic [7:0] wait_reg;

    // Idle forces SE0 unless a pull-up of the peer holds D+
    assign dp_high_o = attach_i || answer_reg || (dp_pullup_i && !idle_i);
    assign se0_o     = !dp_high_o;

    // Pull-up answer to SE0 well inside 3 ms
    always_ff @(posedge clock_i) begin
        if (rst_i || !hnp_i) begin
            answer_reg <= 1'b0;
            wait_reg   <= 8'h00;
        end else if (dp_pulldown_i && se0_o) begin
            wait_reg   <= wait_reg + 8'h01;
            answer_reg <= wait_reg == RESP_CYC[7:0];
        end
    end
endmodule

`default_nettype wire

// ### otg_host_negotiation_bench.sv
// Self-checking bench for the host negotiation block
`timescale 1ns/100ps
`default_nettype none

module otg_host_negotiation_bench;
    localparam int unsigned RST  = 20;
    localparam int unsigned IDLE = 200;
    logic        clock_i  = 1'b0;
    logic        rst_i    = 1'b1;
    logic        cyc_i    = 1'b0;
    logic        stb_i    = 1'b0;
    logic        we_i     = 1'b0;
    logic [3:0]  adr_i    = 4'h0;
    logic [31:0] dat_i    = 32'h0;
    logic        id_pin_i = 1'b0;
    logic        attach   = 1'b0;
    logic        hnp      = 1'b0;
    logic        idle     = 1'b0;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic        ack_o, se0_i, dp_high_i, dp_pulldown_o, dm_pulldown_o;
    logic        dp_pullup_o, drive_vbus_o, bus_reset_o, irq_o;
    logic [2:0]  pads;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          n;

    assign pads = {dp_pulldown_o, dm_pulldown_o, dp_pullup_o};
    always #12.5 clock_i = ~clock_i;

    otg_host_negotiation #(.RESET_CYC(RST), .IDLE_CYC(IDLE))
        i_otg_host_negotiation (
        .clock_i(clock_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .id_pin_i(id_pin_i), .se0_i(se0_i),
        .dp_high_i(dp_high_i), .dp_pulldown_o(dp_pulldown_o),
        .dm_pulldown_o(dm_pulldown_o), .dp_pullup_o(dp_pullup_o),
        .drive_vbus_o(drive_vbus_o), .bus_reset_o(bus_reset_o),
        .irq_o(irq_o));
    otg_peer_model i_otg_peer_model (
        .clock_i(clock_i), .rst_i(rst_i), .attach_i(attach), .hnp_i(hnp),
        .idle_i(idle), .dp_pullup_i(dp_pullup_o),
        .dp_pulldown_i(dp_pulldown_o), .se0_o(se0_i),
        .dp_high_o(dp_high_i));

    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Classic single Wishbone cycle
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge clock_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clock_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        tick(10);
        rst_i <= 1'b0;
        tick(4);
        wb(0, 4'h2, 0);
        check("unmapped", rd, 32'h0);
        wb(0, 4'h4, 0);
        check("stat_a", rd, 32'h01);
        wb(1, 4'hC, 32'h7F);
        attach <= 1'b1;
        tick(8);
        wb(0, 4'h8, 0);
        check("irq_conn", rd, 32'h20);
        check("irq_o_set", irq_o, 1'b1);
        wb(1, 4'h8, 32'h20);
        tick(2);
        check("irq_o_clr", irq_o, 1'b0);
        wb(1, 4'hC, 32'h0);
        wb(1, 4'h0, 32'h03);
        attach <= 1'b0;
        tick(8);
        wb(0, 4'h8, 0);
        check("irq_negdet", rd, 32'h01);
        check("irq_masked", irq_o, 1'b0);
        check("pads_periph", pads, 3'b001);
        check("peer_conn", dp_high_i, 1'b1);
        wb(0, 4'h4, 0);
        check("role_dev", rd[0], 1'b0);
        idle <= 1'b1;
        tick(IDLE + 40);
        wb(0, 4'h8, 0);
        check("irq_back", rd, 32'h0F);
        check("pads_back_a", pads, 3'b110);
        wb(0, 4'h4, 0);
        check("role_host", rd[0], 1'b1);
        idle     <= 1'b0;
        id_pin_i <= 1'b1;
        rst_i    <= 1'b1;
        tick(10);
        rst_i <= 1'b0;
        tick(4);
        wb(0, 4'h4, 0);
        check("stat_b", rd[1:0], 2'b10);
        wb(1, 4'h8, 32'h7F);
        wb(1, 4'hC, 32'h7F);
        wb(1, 4'h0, 32'h0C);
        hnp  <= 1'b1;
        idle <= 1'b1;
        n = 0;
        while (irq_o !== 1'b1) begin
            tick(1);
            n++;
        end
        check("early_time", n >= IDLE && n <= IDLE + 8, 1'b1);
        tick(60);
        wb(0, 4'h8, 0);
        check("irq_swap", rd, 32'h36);
        wb(0, 4'h4, 0);
        check("stat_host", rd, 32'h17);
        check("pads_host", pads, 3'b110);
        idle <= 1'b0;
        wb(1, 4'h0, 32'h1C);
        tick(2);
        check("vbus_on", drive_vbus_o, 1'b1);
        wb(1, 4'h8, 32'h7F);
        wb(1, 4'h0, 32'h3C);
        tick(3);
        check("bus_reset", bus_reset_o, 1'b1);
        tick(RST + 10);
        check("bus_reset_end", bus_reset_o, 1'b0);
        wb(0, 4'h8, 0);
        check("irq_enchg", rd, 32'h40);
        wb(0, 4'h4, 0);
        check("port_en", rd[3], 1'b1);
        wb(1, 4'h8, 32'h40);
        tick(2);
        check("irq_o_low", irq_o, 1'b0);
        wb(1, 4'h0, 32'h1E);
        hnp <= 1'b0;
        tick(10);
        check("pads_back", pads, 3'b001);
        check("vbus_off", drive_vbus_o, 1'b0);
        give_verdict();
    end

    initial begin
        tick(4000);
        num_errors++;
        give_verdict();
    end
endmodule

`default_nettype wire
